// [common/flash_host_pkg.sv]
// package: constants, timing counts and carriers for the flash host block
package flash_host_pkg;
   // ==========================================================
   // widths
   localparam int unsigned FLASH_AW = 23;  // word address bits
   localparam int unsigned FLASH_DW = 16;  // data bus bits
   localparam int unsigned CW       = 16;  // timing counter bits
   // ==========================================================
   // register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_ADDR   = 6'h04;
   localparam logic [5:0] OFS_DATA   = 6'h08;
   localparam logic [5:0] OFS_STATUS = 6'h0C;
   localparam logic [5:0] OFS_EVENT  = 6'h10;
   localparam logic [5:0] OFS_MASK   = 6'h14;
   // ==========================================================
   // control field positions
   localparam int unsigned CTL_PROGRAM = 3;   // arm status-valid wait
   localparam int unsigned CTL_SUSPEND = 4;   // write is a suspend
   localparam int unsigned CTL_RESUME  = 5;   // write is a resume
   localparam int unsigned CTL_PROT_LO = 6;   // 2-bit protect select
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_SET  = 2'h1;
   localparam logic [1:0] PROT_CLR  = 2'h2;
   // status pin positions on the data bus
   localparam int unsigned POLL_BIT = 7;  // poll_status_bit
   localparam int unsigned TOG_BIT  = 6;  // toggle_status_bit
   localparam int unsigned SUSP_BIT = 2;  // suspend_toggle_bit
   // protect address code bits
   localparam int unsigned PA6 = 6;
   localparam int unsigned PA1 = 1;
   localparam int unsigned PA0 = 0;
   // event bits
   localparam int unsigned EV_DONE = 0;
   localparam int unsigned EV_POLL = 1;
   localparam logic [1:0] EVT_RST  = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   // ==========================================================
   // commands
   typedef enum logic [2:0] {
      OP_WRITE = 3'h0, OP_READ = 3'h1, OP_POLL = 3'h2,
      OP_ELEV_ON = 3'h3, OP_ELEV_OFF = 3'h4, OP_HWRESET = 3'h5
   } op_t;
   // ==========================================================
   // timing (ns as printed) and derived cycles at 250 MHz
   localparam int unsigned CLK_NS    = 4;
   localparam int unsigned POLL_NS   = 4000;   // status-valid wait
   localparam int unsigned RSP_NS    = 4000;   // unprotect_setup_time
   localparam int unsigned STROBE_NS = 45;
   localparam int unsigned RECOV_NS  = 30;
   localparam int unsigned ACCESS_NS = 90;
   localparam int unsigned OEPH_NS   = 20;
   localparam int unsigned RP_NS     = 500;
   localparam int unsigned READY_NS  = 20000;
   localparam int unsigned SYNC_CYC  = 2;
   localparam logic [CW-1:0] POLL_CYC   = CW'((POLL_NS+CLK_NS-1)/CLK_NS);
   localparam logic [CW-1:0] RSP_CYC    = CW'((RSP_NS+CLK_NS-1)/CLK_NS);
   localparam logic [CW-1:0] STROBE_CYC =
      CW'((STROBE_NS+CLK_NS-1)/CLK_NS);
   localparam logic [CW-1:0] RECOV_CYC  = CW'((RECOV_NS+CLK_NS-1)/CLK_NS);
   localparam logic [CW-1:0] ACCESS_CYC =
      CW'((ACCESS_NS+CLK_NS-1)/CLK_NS + SYNC_CYC);
   localparam logic [CW-1:0] OEPH_CYC   = CW'((OEPH_NS+CLK_NS-1)/CLK_NS);
   localparam logic [CW-1:0] RP_CYC     = CW'((RP_NS+CLK_NS-1)/CLK_NS);
   localparam int unsigned READY_CYC_DEF = (READY_NS+CLK_NS-1)/CLK_NS;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [5:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [5:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axi_rsp_t;
   typedef struct packed {
      logic                ce_b;   // chip select, low active
      logic                we_b;   // write strobe, low active
      logic                oe_b;   // read strobe, low active
      logic                rst_b;  // hardware reset, low active
      logic                elev;   // elevated_unlock_level on reset pin
      logic                dq_oe;  // host drives data bus
      logic [FLASH_AW-1:0] addr;
      logic [FLASH_DW-1:0] dq;
   } flash_pins_t;
endpackage

// [design/flash_host.sv]
// flash host: drives command, status polling and protect cycles of a NOR flash
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
   parameter int unsigned READY_CYC = flash_host_pkg::READY_CYC_DEF
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_b_i,
   input  wire flash_host_pkg::axi_req_t        axi_i,
   output var  flash_host_pkg::axi_rsp_t        axi_o,
   output var  flash_host_pkg::flash_pins_t     pins_o,
   input  wire logic [flash_host_pkg::FLASH_DW-1:0] dq_i,
   output logic                                 irq_o
);
   import flash_host_pkg::*;

   // ==========================================================
   // state
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_WR_LO = 3'h1, S_WR_HI = 3'h3, S_WAIT = 3'h2,
      S_RD_LO = 3'h6, S_RD_HI = 3'h7, S_RST = 3'h5, S_PWAIT = 3'h4
   } fsm_t;

   typedef struct packed {
      fsm_t                fsm;      // sequencer state
      logic [CW-1:0]       cnt;      // phase down-counter
      logic [CW-1:0]       ptmr;     // status-valid wait timer
      logic                poll_ok;  // wait has elapsed
      logic                rewait;   // suspended inside the wait
      logic                elev_ok;  // elevated level settled
      logic                first;    // no previous status read yet
      logic                prev_tog; // toggle bit of previous read
      logic [7:0]          ctl;      // latched command word
      logic [FLASH_AW-1:0] addr;     // target address
      logic [FLASH_DW-1:0] wdata;    // write data / expected data
      logic [FLASH_DW-1:0] rd;       // last sampled read data
      logic [FLASH_DW-1:0] dq_s1;    // synchroniser stage one
      logic [FLASH_DW-1:0] dq_s2;    // synchroniser stage two
      logic [1:0]          evt;      // sticky events
      logic [1:0]          mask;     // interrupt mask
      logic                aw_got;   // write address captured
      logic [5:0]          awaddr;
      logic                w_got;    // write data captured
      logic [31:0]         wd;
      axi_rsp_t            axi;
      flash_pins_t         pin;
      logic                irq;
   } st_t;

   st_t s;       // registered state
   st_t next_s;  // next state

   // decode of a register read, used by the read channel
   function automatic logic [31:0] reg_read(input st_t c, input logic [5:0] a);
      logic [31:0] v;
      v = 32'h0;
      unique case (a)
         OFS_CTRL:   v = {24'h0, c.ctl};
         OFS_ADDR:   v = {{(32-FLASH_AW){1'b0}}, c.addr};
         OFS_DATA:   v = {16'h0, c.wdata};
         OFS_STATUS: v = {c.rd, 11'h0, c.elev_ok, c.pin.elev, c.rewait,
                          c.poll_ok, c.fsm != S_IDLE};
         OFS_EVENT:  v = {30'h0, c.evt};
         OFS_MASK:   v = {30'h0, c.mask};
         default:    v = 32'h0;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      return a == OFS_CTRL || a == OFS_ADDR || a == OFS_DATA ||
             a == OFS_STATUS || a == OFS_EVENT || a == OFS_MASK;
   endfunction

   // ==========================================================
   // next-state logic
   always_comb begin
      logic        do_wr;     // register write this cycle
      logic        ev_clr;    // event register is being read
      logic [1:0]  ev_set;    // events raised this cycle
      logic        last;      // phase count reached zero
      logic        stat_done; // status shows operation over
      op_t         op;
      do_wr     = 1'b0;
      ev_clr    = 1'b0;
      ev_set    = 2'h0;
      stat_done = 1'b0;
      next_s    = s;
      last      = s.cnt == '0;
      op        = op_t'(s.ctl[2:0]);
      // pin inputs pass two flops before use
      next_s.dq_s1 = dq_i;
      next_s.dq_s2 = s.dq_s1;
      if (!last) begin
         next_s.cnt = s.cnt - CW'(1);
      end
      if (!s.poll_ok && !s.rewait) begin
         if (s.ptmr == POLL_CYC - CW'(1)) begin
            next_s.poll_ok = 1'b1;
         end
         next_s.ptmr = s.ptmr + CW'(1);
      end

      // ---- write channel: address and data in either order
      if (axi_i.awvalid && s.axi.awready) begin
         next_s.aw_got      = 1'b1;
         next_s.awaddr      = axi_i.awaddr;
         next_s.axi.awready = 1'b0;
      end
      if (axi_i.wvalid && s.axi.wready) begin
         next_s.w_got      = 1'b1;
         next_s.wd         = axi_i.wdata;
         next_s.axi.wready = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.axi.bvalid) begin
         do_wr             = 1'b1;
         next_s.aw_got     = 1'b0;
         next_s.w_got      = 1'b0;
         next_s.axi.bvalid = 1'b1;
         next_s.axi.bresp  = mapped(s.awaddr) ? 2'h0 : 2'h2;
      end
      if (s.axi.bvalid && axi_i.bready) begin
         next_s.axi.bvalid  = 1'b0;
         next_s.axi.awready = 1'b1;
         next_s.axi.wready  = 1'b1;
      end
      // ---- read channel
      if (axi_i.arvalid && s.axi.arready) begin
         next_s.axi.arready = 1'b0;
         next_s.axi.rvalid  = 1'b1;
         next_s.axi.rdata   = reg_read(s, axi_i.araddr);
         next_s.axi.rresp   = mapped(axi_i.araddr) ? 2'h0 : 2'h2;
         ev_clr             = axi_i.araddr == OFS_EVENT;
      end
      if (s.axi.rvalid && axi_i.rready) begin
         next_s.axi.rvalid  = 1'b0;
         next_s.axi.arready = 1'b1;
      end

      // ---- register writes; a command while busy is ignored
      if (do_wr) begin
         if (s.awaddr == OFS_ADDR && s.fsm == S_IDLE) begin
            next_s.addr = s.wd[FLASH_AW-1:0];
         end
         if (s.awaddr == OFS_DATA && s.fsm == S_IDLE) begin
            next_s.wdata = s.wd[FLASH_DW-1:0];
         end
         if (s.awaddr == OFS_MASK) begin
            next_s.mask = s.wd[1:0];
         end
         if (s.awaddr == OFS_CTRL && s.fsm == S_IDLE) begin
            next_s.ctl   = s.wd[7:0];
            next_s.first = 1'b1;
            unique case (op_t'(s.wd[2:0]))
               OP_WRITE: begin
                  if (s.wd[CTL_PROT_LO+:2] != PROT_NONE) begin
                     next_s.addr[PA6] = s.wd[CTL_PROT_LO+:2] == PROT_CLR;
                     next_s.addr[PA1] = 1'b1;
                     next_s.addr[PA0] = 1'b0;
                  end
                  // no writes until elevated level settled
                  if (!s.pin.elev || s.elev_ok) begin
                     next_s.fsm = S_WR_LO;
                     next_s.cnt = STROBE_CYC - CW'(1);
                  end else begin
                     ev_set[EV_DONE] = 1'b1;
                  end
               end
               OP_READ: begin
                  next_s.fsm = S_RD_LO;
                  next_s.cnt = ACCESS_CYC - CW'(1);
               end
               // polling waits for the valid timer
               OP_POLL: next_s.fsm = S_PWAIT;
               OP_ELEV_ON: begin
                  next_s.pin.elev = 1'b1;
                  next_s.elev_ok  = 1'b0;
                  next_s.fsm      = S_WAIT;
                  next_s.cnt      = RSP_CYC - CW'(1);
               end
               OP_ELEV_OFF: begin
                  next_s.pin.elev = 1'b0;
                  next_s.elev_ok  = 1'b0;
                  ev_set[EV_DONE] = 1'b1;
               end
               OP_HWRESET: begin
                  next_s.pin.rst_b = 1'b0;
                  next_s.fsm       = S_RST;
                  next_s.cnt       = RP_CYC - CW'(1);
               end
               default: ev_set[EV_DONE] = 1'b1;
            endcase
         end
      end

      // ---- bus sequencer
      unique case (s.fsm)
         S_IDLE: ;
         S_WR_LO: begin
            next_s.pin.ce_b  = 1'b0;
            next_s.pin.we_b  = 1'b0;
            next_s.pin.dq_oe = 1'b1;
            next_s.pin.dq    = s.wdata;
            next_s.pin.addr  = s.addr;
            if (last) begin
               next_s.pin.we_b = 1'b1;
               next_s.pin.ce_b = 1'b1;
               next_s.fsm      = S_WR_HI;
               next_s.cnt      = RECOV_CYC - CW'(1);
            end
         end
         S_WR_HI: if (last) begin
            next_s.pin.dq_oe = 1'b0;
            next_s.fsm       = S_IDLE;
            ev_set[EV_DONE]  = 1'b1;
            if (s.ctl[CTL_PROGRAM]) begin
               next_s.ptmr    = '0;
               next_s.poll_ok = 1'b0;
               next_s.rewait  = 1'b0;
            end
            if (s.ctl[CTL_SUSPEND] && !s.poll_ok) begin
               next_s.rewait = 1'b1;
            end
            if (s.ctl[CTL_RESUME] && s.rewait) begin
               next_s.ptmr   = '0;
               next_s.rewait = 1'b0;
            end
         end
         S_PWAIT: if (s.poll_ok) begin
            next_s.fsm = S_RD_LO;
            next_s.cnt = ACCESS_CYC - CW'(1);
         end
         // status read at the latched address
         S_RD_LO: begin
            next_s.pin.addr = s.addr;
            next_s.pin.ce_b = 1'b0;
            next_s.pin.oe_b = 1'b0;
            if (last) begin
               next_s.pin.oe_b = 1'b1;
               next_s.pin.ce_b = 1'b1;
               next_s.rd       = s.dq_s2;
               next_s.fsm      = S_RD_HI;
               next_s.cnt      = OEPH_CYC - CW'(1);
            end
         end
         S_RD_HI: if (last) begin
            stat_done = !s.first &&
                        (s.rd[POLL_BIT] == s.wdata[POLL_BIT] ||
                         s.rd[TOG_BIT] == s.prev_tog);
            next_s.first    = 1'b0;
            next_s.prev_tog = s.rd[TOG_BIT];
            if (op == OP_POLL && !stat_done) begin
               next_s.fsm = S_RD_LO;
               next_s.cnt = ACCESS_CYC - CW'(1);
            end else begin
               next_s.fsm      = S_IDLE;
               ev_set[EV_DONE] = 1'b1;
               ev_set[EV_POLL] = op == OP_POLL;
            end
         end
         S_RST: if (last) begin
            next_s.pin.rst_b = 1'b1;
            next_s.fsm       = S_WAIT;
            next_s.cnt       = CW'(READY_CYC - 1);
         end
         S_WAIT: if (last) begin
            next_s.elev_ok  = s.pin.elev;
            next_s.fsm      = S_IDLE;
            ev_set[EV_DONE] = 1'b1;
         end
      endcase

      // sticky events: a new event wins over the read clear
      next_s.evt = (ev_clr ? 2'h0 : s.evt) | ev_set;
      next_s.irq = |(next_s.evt & s.mask);
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s                 <= '0;
         s.fsm             <= S_IDLE;
         s.poll_ok         <= 1'b1;
         s.evt             <= EVT_RST;
         s.mask            <= MASK_RST;
         s.axi.awready     <= 1'b1;
         s.axi.wready      <= 1'b1;
         s.axi.arready     <= 1'b1;
         s.pin.ce_b        <= 1'b1;
         s.pin.we_b        <= 1'b1;
         s.pin.oe_b        <= 1'b1;
         s.pin.rst_b       <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign axi_o  = s.axi;
   assign pins_o = s.pin;
   assign irq_o  = s.irq;
endmodule
`default_nettype wire

// [tb/flash_model.sv]
// device model: status bits of a parallel flash as seen at its pins
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
   // typical program time, scaled down to keep runs short
   parameter int BUSY_NS = 6000
) (
   input  wire flash_host_pkg::flash_pins_t pins_i,
   output logic [15:0]                      dq_o
);
   import flash_host_pkg::*;
   // ==========================================================
   // state
   logic [15:0] last  = 16'h0000;  // data of the last write cycle
   logic [15:0] rdq   = 16'h0000;  // value of the last read
   logic [22:0] waddr;             // address of the last write
   logic [22:0] raddr;             // address of the last read
   logic        tog   = 1'b0;      // toggle bit state
   time         bend  = 0;         // end of the embedded algorithm
   time         t_rd1 = 0;         // first read after a write
   int          nwr   = 0;         // write cycles seen
   int          nrst  = 0;         // hardware resets seen
   logic        armed = 1'b0;      // write strobe fell while selected
   // ==========================================================
   // a write cycle starts the embedded algorithm
   // select may rise with the strobe, so selection is noted at the fall
   always @(negedge pins_i.we_b) begin
      armed = pins_i.ce_b === 1'b0;
   end
   always @(posedge pins_i.we_b) begin
      if (armed) begin
         armed = 1'b0;
         last = pins_i.dq;
         waddr = pins_i.addr;
         nwr++;
         bend = $time + BUSY_NS;
         t_rd1 = 0;
      end
   end
   // status while busy at any address, true data after
   always @(negedge pins_i.oe_b) begin
      if (pins_i.ce_b === 1'b0) begin
         raddr = pins_i.addr;
         if (t_rd1 == 0) t_rd1 = $time;
         tog = ~tog;
         // no sector is erase-suspended, so that bit never toggles
         if ($time < bend) rdq = {last[15:8], ~last[7], tog, 4'h0, last[1:0]};
         else rdq = last;
      end
   end
   always @(negedge pins_i.rst_b) begin
      bend = $time;
      nrst++;
   end
   // released bus shows the inverse of the last value, never a hold
   assign dq_o = (!pins_i.ce_b && !pins_i.oe_b && !pins_i.dq_oe) ? rdq : ~rdq;
endmodule
`default_nettype wire

// [tb/flash_host_sva.sv]
// checker: host-side timing of the flash pins and the register bus
`timescale 1ns/1ps
`default_nettype none
module flash_host_sva (
   input wire logic                          clk_i,
   input wire logic                          rst_b_i,
   input wire flash_host_pkg::axi_req_t      axi_i,
   input wire flash_host_pkg::axi_rsp_t      axi_o,
   input wire flash_host_pkg::flash_pins_t   pins_o,
   input wire logic [flash_host_pkg::FLASH_DW-1:0] dq_i,
   input wire logic                          irq_o
);
   import flash_host_pkg::*;
   logic [5:0]  aw_q;   // last write address taken
   logic [31:0] w_q;    // last write data taken
   logic        bv_q;   // bvalid one cycle ago
   logic        frz;    // status wait frozen by suspend
   logic        pol_q;  // last command was a poll
   logic [1:0]  pr_q;   // protect code of the last command
   logic [10:0] wcnt;   // cycles left of the status wait
   logic [10:0] ecnt;   // cycles the elevated level has stood
   wire ctrl_wr = axi_o.bvalid && !bv_q && aw_q == OFS_CTRL;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // ==========================================================
   // helper: wait model, seen one cycle late so reloads use 999
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {aw_q, w_q, bv_q, frz, pol_q, pr_q, wcnt, ecnt} <= '0;
      end else begin
         bv_q <= axi_o.bvalid;
         if (axi_i.awvalid && axi_o.awready) aw_q <= axi_i.awaddr;
         if (axi_i.wvalid && axi_o.wready) w_q <= axi_i.wdata;
         if (ctrl_wr) pol_q <= w_q[2:0] == OP_POLL;
         if (ctrl_wr) pr_q <= w_q[CTL_PROT_LO+:2];
         if (ctrl_wr && w_q[CTL_RESUME] && frz) begin
            wcnt <= 11'd999;
            frz <= 1'b0;
         end else if (ctrl_wr && w_q[CTL_SUSPEND] && wcnt != 0) begin
            frz <= 1'b1;
         end else if (ctrl_wr && w_q[CTL_PROGRAM]) begin
            wcnt <= 11'd999;
         end else if (!frz && wcnt != 0) begin
            wcnt <= wcnt - 11'd1;
         end
         ecnt <= !pins_o.elev ? 11'd0 : ecnt + {10'd0, ecnt != 11'h7FF};
      end
   end
   // ==========================================================
   // assertions
   a_oe_gap: assert property (
      $rose(pins_o.oe_b) |-> pins_o.oe_b[*5]) else $error("read gap short");
   a_poll_wait: assert property (
      $fell(pins_o.oe_b) && pol_q |-> wcnt == 0) else $error("early poll");
   a_rewait_read: assert property (
      $fell(pins_o.oe_b) && pol_q |-> !frz) else $error("poll while held");
   a_prot_code: assert property (
      $fell(pins_o.ce_b) && pr_q != PROT_NONE |->
      {pins_o.addr[PA6], pins_o.addr[PA1], pins_o.addr[PA0]}
      == {pr_q == PROT_CLR, 2'b10}) else $error("protect code wrong");
   a_elev_setup: assert property (
      $fell(pins_o.we_b) && pins_o.elev |-> ecnt >= 11'd1000)
      else $error("write before setup time");
   a_rst_pulse: assert property (
      $fell(pins_o.rst_b) |-> (!pins_o.rst_b throughout ##124 1'b1)
      ##1 pins_o.rst_b) else $error("reset pulse width wrong");
   a_rst_ready: assert property (
      $rose(pins_o.rst_b) |-> pins_o.ce_b[*8]) else $error("access too soon");
   a_b_hold: assert property (
      axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid)
      else $error("write response dropped");
endmodule
bind flash_host flash_host_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .axi_i(axi_i), .axi_o(axi_o), .pins_o(pins_o), .dq_i(dq_i),
   .irq_o(irq_o));
`default_nettype wire

// [tb/test_flash_host.sv]
// testbench: flash host driven over its register bus against a device model
`timescale 1ns/1ps
`default_nettype none
module test_flash_host;
   import flash_host_pkg::*;
   // ==========================================================
   // signals
   logic        clk_i   = 1'b0;
   logic        rst_b_i = 1'b0;
   axi_req_t    axi_i   = '0;
   axi_rsp_t    axi_o;
   flash_pins_t pins_o;
   logic [15:0] dq_i;
   logic        irq_o;
   int          err_total = 0;
   int          samples_checked = 0;
   logic [31:0] rv, d, a;  // read word, random data and address
   logic [1:0]  rr;        // read response
   time         t0;        // start of a status wait
   int          k;
   initial forever #2 clk_i = ~clk_i;
   flash_host #(.READY_CYC(20)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .axi_i(axi_i), .axi_o(axi_o), .pins_o(pins_o), .dq_i(dq_i),
      .irq_o(irq_o));
   flash_model u_mem (.pins_i(pins_o), .dq_o(dq_i));
   // ==========================================================
   // tasks; bus values are read before the edge's updates land
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] ad, input logic [31:0] dt);
      axi_i.awaddr <= ad;
      axi_i.wdata <= dt;
      {axi_i.awvalid, axi_i.wvalid, axi_i.bready} <= 3'h7;
      forever begin
         @(posedge clk_i);
         if (axi_o.awready) axi_i.awvalid <= 1'b0;
         if (axi_o.wready) axi_i.wvalid <= 1'b0;
         if (axi_o.bvalid) break;
      end
      axi_i.bready <= 1'b0;
      // an edge passes so a following call never reassigns bready at once
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [5:0] ad);
      axi_i.araddr <= ad;
      {axi_i.arvalid, axi_i.rready} <= 2'h3;
      forever begin
         @(posedge clk_i);
         if (axi_o.arready) axi_i.arvalid <= 1'b0;
         if (axi_o.rvalid) break;
      end
      rv = axi_o.rdata;
      rr = axi_o.rresp;
      axi_i.rready <= 1'b0;
      // an edge passes so a following call never reassigns rready at once
      @(posedge clk_i);
   endtask
   // wait for the interrupt under a bound, then clear the events
   task automatic wirq();
      int n;
      n = 0;
      while (irq_o !== 1'b1 && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      chk(irq_o, 1'b1);
      rd(OFS_EVENT);
      chk(rv[0], 1'b1);
   endtask
   task automatic prog();
      d = $urandom;
      a = $urandom;
      wr(OFS_ADDR, a);
      wr(OFS_DATA, d);
      wr(OFS_CTRL, 32'h8 | OP_WRITE);
      t0 = $time;
      wirq();
      chk(u_mem.last, d[15:0]);
      chk(u_mem.waddr, a[22:0]);
   endtask
   task automatic poll();
      wr(OFS_CTRL, 32'(OP_POLL));
      wirq();
      chk(rv[1], 1'b1);
      chk(u_mem.t_rd1 >= t0 + 999 * 4, 1'b1);
      rd(OFS_STATUS);
      chk(rv[31:16], d[15:0]);
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================================
   // watchdog: the sequence needs well under 75000 cycles
   initial begin
      #300000;
      err_total++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      void'($urandom(16));
      rd(OFS_STATUS);
      chk(rv[4:0], 5'h02);
      rd(OFS_EVENT);
      chk(rv, {30'h0, EVT_RST});
      rd(6'h18);
      chk(rr, 2'h2);
      wr(OFS_MASK, 32'h3);
      prog();
      poll();
      // suspend inside the wait, resume restarts it in full
      prog();
      wr(OFS_CTRL, 32'h10 | OP_WRITE);
      wirq();
      rd(OFS_STATUS);
      chk(rv[2], 1'b1);
      repeat (1200) @(posedge clk_i);
      wr(OFS_CTRL, 32'h20 | OP_WRITE);
      t0 = $time;
      wirq();
      poll();
      for (k = 1; k < 3; k++) begin
         wr(OFS_CTRL, (k << CTL_PROT_LO) | OP_WRITE);
         wirq();
         chk({u_mem.waddr[6], u_mem.waddr[1:0]}, {k == 2, 2'b10});
      end
      wr(OFS_CTRL, 32'(OP_ELEV_ON));
      wirq();
      wr(OFS_CTRL, 32'(OP_WRITE));
      wirq();
      repeat (1000) @(posedge clk_i);
      k = u_mem.nwr;
      wr(OFS_CTRL, 32'(OP_WRITE));
      wirq();
      chk(u_mem.nwr, k + 1);
      rd(OFS_STATUS);
      chk(rv[4:3], 2'b11);
      wr(OFS_CTRL, 32'(OP_ELEV_OFF));
      wirq();
      k = u_mem.nrst;
      wr(OFS_CTRL, 32'(OP_HWRESET));
      wirq();
      chk(u_mem.nrst, k + 1);
      // masked event: no interrupt, event still recorded
      wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, 32'(OP_READ));
      repeat (100) @(posedge clk_i);
      chk(irq_o, 1'b0);
      rd(OFS_EVENT);
      chk(rv[0], 1'b1);
      results();
   end
endmodule
`default_nettype wire
